// ===== design/uart_ifc_regs.svh
`ifndef UART_IFC_REGS_SVH
`define UART_IFC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_INTERRUPT_ENABLE 8'h00
`define OFS_INTERRUPT_IDENT 8'h04
`define OFS_ENHANCED_FEATURE 8'h08
`define OFS_FIFO_CONTROL 8'h0C
`define OFS_MODEM_CONTROL 8'h10
`define OFS_MODEM_STATUS 8'h14
`define OFS_FLOW_THRESHOLD 8'h18
`define OFS_SPECIAL_CHAR 8'h1C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_PINS 4'hF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IE_RX_DATA 0
`define IE_TX_HOLD 1
`define IE_LINE 2
`define IE_MODEM 3
`define IE_SLEEP 4
`define IE_XOFF 5
`define IE_RTS 6
`define IE_CTS 7
`define EF_CTS_FLOW 7
`define EF_RTS_FLOW 6
`define EF_SPECIAL 5
`define EF_WR_ENABLE 4
`define FC_FIFO_EN 0
`define MC_RTS 1
`define MC_DTR 0
`define MC_THRESH_EN 6
`define IE_PROT_MASK 8'hF0
`define FC_PROT_MASK 8'h30
`define MC_PROT_MASK 8'hE0

// ----------------------------------------
// Identification codes
// ----------------------------------------
`define ID_NONE 6'h01
`define ID_LINE 6'h06
`define ID_TIMEOUT 6'h0C
`define ID_RX_DATA 6'h04
`define ID_TX_HOLD 6'h02
`define ID_MODEM 6'h00
`define ID_XOFF 6'h10
`define ID_CTS_RTS 6'h20

`endif

// ===== design/uart_ifc_pkg.sv
package uart_ifc_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [5:0] iid_t;

	typedef struct packed {
		logic [3:0] prev;
		logic [3:0] delta;
	} modem_state_t;

	typedef struct packed {
		byte_t interrupt_enable;
		byte_t enhanced_feature_control;
		byte_t fifo_control;
		byte_t modem_control;
		byte_t flow_threshold;
		byte_t spc;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic cts_p;
		logic tx_below_p;
		logic thr_pend;
		logic xoff_pend;
		logic cts_rise;
		logic rts_rise;
		logic rts_n;
		logic irq_n;
		logic tx_stop;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		iid_t rd_src;
		logic rd_iir;
		logic rd_msr;
	} ifc_state_t;

endpackage

// ===== design/modem_change.sv
`include "uart_ifc_regs.svh"

module modem_change
	import uart_ifc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] act_i,
	input wire logic clear_i,
	output logic [3:0] delta_o
);

	modem_state_t q, d;

	// ----------------------------------------
	// Change flags
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.prev = act_i;
		if (clear_i)
			d.delta = 4'h0;
		// Set wins over a read in the same cycle
		d.delta[0] = d.delta[0] | (act_i[0] ^ q.prev[0]); // see RL18
		d.delta[1] = d.delta[1] | (act_i[1] ^ q.prev[1]); // see RL18
		d.delta[2] = d.delta[2] | (q.prev[2] & ~act_i[2]); // see RL18
		d.delta[3] = d.delta[3] | (act_i[3] ^ q.prev[3]); // see RL18
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign delta_o = q.delta;

endmodule

// ===== design/iid_encode.sv
`include "uart_ifc_regs.svh"

module iid_encode
	import uart_ifc_pkg::*;
(
	input wire logic [7:0] ier_i,
	input wire logic line_err_i,
	input wire logic rx_timeout_i,
	input wire logic rx_data_i,
	input wire logic thr_i,
	input wire logic modem_i,
	input wire logic xoff_i,
	input wire logic cts_rise_i,
	input wire logic rts_rise_i,
	output logic pending_o,
	output iid_t id_o
);

	// ----------------------------------------
	// Priority selection
	// ----------------------------------------
	always_comb
	begin
		pending_o = 1'b1;
		if (ier_i[`IE_LINE] && line_err_i)
			id_o = `ID_LINE; // see RL9
		else if (ier_i[`IE_RX_DATA] && rx_timeout_i)
			id_o = `ID_TIMEOUT; // see RL9
		else if (ier_i[`IE_RX_DATA] && rx_data_i)
			id_o = `ID_RX_DATA; // see RL9
		else if (ier_i[`IE_TX_HOLD] && thr_i)
			id_o = `ID_TX_HOLD; // see RL9
		else if (ier_i[`IE_MODEM] && modem_i)
			id_o = `ID_MODEM; // see RL10
		else if (ier_i[`IE_XOFF] && xoff_i)
			id_o = `ID_XOFF; // see RL10 RL11
		else if ((ier_i[`IE_CTS] && cts_rise_i) || (ier_i[`IE_RTS] && rts_rise_i))
			id_o = `ID_CTS_RTS; // see RL10 RL12
		else
		begin
			id_o = `ID_NONE; // see RL8 RL19
			pending_o = 1'b0;
		end
	end

endmodule

// ===== design/uart_ifc_ctrl.sv
// Overview of operation
// RL1: Enable bits 0-3 gate data, transmit, line status, modem interrupts; reset off.
// RL2: Enable bits 5-7 gate Xoff, RTS and CTS interrupts; reset off.
// RL3: Enable bit 4 selects sleep mode; clear by default.
// RL4: Enable bits 7:4 accept writes only with enhanced write enable set.
// RL5: Re-enabling the transmit interrupt below threshold raises no new interrupt.
// RL6: Active-low interrupt output asserts whenever an enabled source is pending.
// RL7: Identification register is read-only; bits 7:6 mirror FIFO enable.
// RL8: Identification bit 0 reads 0 when pending, 1 when idle.
// RL9: Priority 1 line error, 2 timeout/data, 3 transmit holding.
// RL10: Priority 4 modem, 5 Xoff/special, 6 CTS/RTS going high.
// RL11: Identification bit 4 reports Xoff or special character detection.
// RL12: Identification bit 5 reports CTS input or RTS output rising.
// RL13: With feature bit 7, high CTS stops the transmitter.
// RL14: With feature bit 6, RTS high at halt level, low at resume.
// RL15: With feature bit 5, match special character, keep it, flag bit 4.
// RL16: Feature bit 4 write-enables enable 7:4, FIFO 5:4, modem 7:5.
// RL17: Feature bits 3:0 select the software flow control combination.
// RL18: Modem change flags record edges, ring on release, cleared by status read.
// RL19: Interrupt output releases and identification idles once nothing is pending.

`include "uart_ifc_regs.svh"

module uart_ifc_ctrl
	import uart_ifc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic line_err_i,
	input wire logic rx_timeout_i,
	input wire logic rx_data_i,
	input wire logic tx_below_i,
	input wire logic [6:0] rx_level_i,
	input wire logic rx_char_valid_i,
	input wire logic [7:0] rx_char_i,
	input wire logic xoff_rcvd_i,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic cd_n_i,
	output logic irq_n_o,
	output logic rts_n_o,
	output logic dtr_n_o,
	output logic tx_stop_o,
	output logic sleep_o,
	output logic [3:0] sw_flow_mode_o,
	output logic [7:0] fifo_control_o,
	output logic [7:0] modem_control_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Thresholds count in steps of four bytes
	function automatic logic [6:0] level_of(input logic [3:0] nib);
		level_of = {1'b0, nib, 2'b00};
	endfunction

	// Keep protected bits unless the write enable is open
	function automatic byte_t guarded(input byte_t old, input byte_t wr, input byte_t prot, input logic open);
		guarded = open ? wr : ((wr & ~prot) | (old & prot));
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == `OFS_INTERRUPT_ENABLE) || (a == `OFS_INTERRUPT_IDENT) ||
			(a == `OFS_ENHANCED_FEATURE) || (a == `OFS_FIFO_CONTROL) ||
			(a == `OFS_MODEM_CONTROL) || (a == `OFS_MODEM_STATUS) ||
			(a == `OFS_FLOW_THRESHOLD) || (a == `OFS_SPECIAL_CHAR);
	endfunction

	ifc_state_t q, d;

	logic [3:0] act;
	logic [3:0] delta;
	logic msr_clear;
	logic pending;
	iid_t cur_id;
	logic setup;
	logic access;
	logic wr;
	logic wr_open;
	logic special_hit;
	byte_t wbyte;
	byte_t rd_val;

	// ----------------------------------------
	// Modem inputs
	// ----------------------------------------
	// Pins are active low; status bits are active high
	assign act = ~q.pin_s2;

	modem_change u_modem_change (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.act_i(act),
		.clear_i(msr_clear),
		.delta_o(delta)
	);

	iid_encode u_iid_encode (
		.ier_i(q.interrupt_enable),
		.line_err_i(line_err_i),
		.rx_timeout_i(rx_timeout_i),
		.rx_data_i(rx_data_i),
		.thr_i(q.thr_pend),
		.modem_i(|delta),
		.xoff_i(q.xoff_pend),
		.cts_rise_i(q.cts_rise),
		.rts_rise_i(q.rts_rise),
		.pending_o(pending),
		.id_o(cur_id)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i & q.pready;
	assign wr = access & pwrite_i & ~q.pslverr;
	assign wr_open = q.enhanced_feature_control[`EF_WR_ENABLE];
	assign wbyte = pwdata_i[7:0];
	assign msr_clear = q.rd_msr & access;
	assign special_hit = q.enhanced_feature_control[`EF_SPECIAL] & rx_char_valid_i & (rx_char_i == q.spc);

	always_comb
	begin
		rd_val = `RST_BYTE;
		unique case (paddr_i)
			`OFS_INTERRUPT_ENABLE:
				rd_val = q.interrupt_enable;
			`OFS_INTERRUPT_IDENT:
				rd_val = {{2{q.fifo_control[`FC_FIFO_EN]}}, cur_id}; // see RL7 RL8
			`OFS_ENHANCED_FEATURE:
				rd_val = q.enhanced_feature_control;
			`OFS_FIFO_CONTROL:
				rd_val = q.fifo_control;
			`OFS_MODEM_CONTROL:
				rd_val = q.modem_control;
			`OFS_MODEM_STATUS:
				rd_val = {act[3], act[2], act[1], act[0], delta};
			`OFS_FLOW_THRESHOLD:
				rd_val = q.flow_threshold;
			`OFS_SPECIAL_CHAR:
				rd_val = q.spc;
			default:
				rd_val = `RST_BYTE;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		d = q;

		// Two stages before anything looks at a pin
		d.pin_s1 = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
		d.pin_s2 = q.pin_s1;
		d.cts_p = q.pin_s2[0];
		d.tx_below_p = tx_below_i;

		// Answer one cycle after setup, data latched at setup
		d.pready = setup;
		d.pslverr = setup & ~known_addr(paddr_i);
		if (setup)
		begin
			d.prdata = {24'h000000, rd_val};
			d.rd_src = cur_id;
			d.rd_iir = ~pwrite_i & pending & (paddr_i == `OFS_INTERRUPT_IDENT);
			d.rd_msr = ~pwrite_i & (paddr_i == `OFS_MODEM_STATUS);
		end
		else if (!psel_i)
		begin
			d.rd_iir = 1'b0;
			d.rd_msr = 1'b0;
		end

		// Register writes
		if (wr)
		begin
			unique case (paddr_i)
				`OFS_INTERRUPT_ENABLE:
				begin
					d.interrupt_enable = guarded(q.interrupt_enable, wbyte, `IE_PROT_MASK, wr_open); // see RL1 RL2 RL3 RL4 RL16
					if (wbyte[`IE_TX_HOLD] && !q.interrupt_enable[`IE_TX_HOLD])
						d.thr_pend = 1'b0; // see RL5
				end
				`OFS_ENHANCED_FEATURE:
					d.enhanced_feature_control = wbyte; // see RL17
				`OFS_FIFO_CONTROL:
					d.fifo_control = guarded(q.fifo_control, wbyte, `FC_PROT_MASK, wr_open); // see RL16
				`OFS_MODEM_CONTROL:
					d.modem_control = guarded(q.modem_control, wbyte, `MC_PROT_MASK, wr_open); // see RL16
				`OFS_FLOW_THRESHOLD:
				begin
					if (wr_open && q.modem_control[`MC_THRESH_EN])
						d.flow_threshold = wbyte;
				end
				`OFS_SPECIAL_CHAR:
					d.spc = wbyte;
				default:
					d.spc = q.spc;
			endcase
		end

		// Reading the identification register retires edge sources
		if (q.rd_iir && access)
		begin
			if (q.rd_src == `ID_TX_HOLD)
				d.thr_pend = 1'b0;
			if (q.rd_src == `ID_XOFF)
				d.xoff_pend = 1'b0;
			if (q.rd_src == `ID_CTS_RTS)
			begin
				d.cts_rise = 1'b0;
				d.rts_rise = 1'b0;
			end
		end

		// Transmit interrupt follows the falling edge into the threshold only
		if (!tx_below_i)
			d.thr_pend = 1'b0;
		if (tx_below_i && !q.tx_below_p)
			d.thr_pend = 1'b1; // see RL5

		// Event sets come last so they win over clears
		if (xoff_rcvd_i || special_hit)
			d.xoff_pend = 1'b1; // see RL11 RL15
		if (q.pin_s2[0] && !q.cts_p)
			d.cts_rise = 1'b1; // see RL12

		// Hardware flow control on the request line
		if (q.enhanced_feature_control[`EF_RTS_FLOW])
		begin
			if (rx_level_i >= level_of(q.flow_threshold[3:0]))
				d.rts_n = 1'b1; // see RL14
			else if (rx_level_i <= level_of(q.flow_threshold[7:4]))
				d.rts_n = 1'b0; // see RL14
		end
		else
			d.rts_n = ~q.modem_control[`MC_RTS];
		if (d.rts_n && !q.rts_n)
			d.rts_rise = 1'b1; // see RL12

		// Stop sending while the peer holds its clear line high
		d.tx_stop = q.enhanced_feature_control[`EF_CTS_FLOW] & q.pin_s2[0]; // see RL13

		d.irq_n = ~pending; // see RL6 RL19
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			q <= '0;
			q.pin_s1 <= `RST_PINS;
			q.pin_s2 <= `RST_PINS;
			q.cts_p <= 1'b1;
			q.rts_n <= 1'b1;
			q.irq_n <= 1'b1;
		end
		else
			q <= d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign irq_n_o = q.irq_n;
	assign rts_n_o = q.rts_n;
	assign dtr_n_o = ~q.modem_control[`MC_DTR];
	assign tx_stop_o = q.tx_stop;
	assign sleep_o = q.interrupt_enable[`IE_SLEEP]; // see RL3
	assign sw_flow_mode_o = q.enhanced_feature_control[3:0]; // see RL17
	assign fifo_control_o = q.fifo_control;
	assign modem_control_o = q.modem_control;

endmodule

// ===== bench/apb_host.sv
module apb_host
(
	input wire logic ref_clk_i,
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	// Request held until pready is seen; no latency assumed
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge ref_clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= {24'h0, d};
		@(posedge ref_clk_i);
		penable_o <= 1'b1;
		do
			@(posedge ref_clk_i);
		while (pready_i !== 1'b1);
		r = prdata_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule

// ===== bench/uart_ifc_properties.sv
`include "uart_ifc_regs.svh"

module uart_ifc_props
	import uart_ifc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic cts_n_i,
	input wire logic irq_n_o,
	input wire logic rts_n_o,
	input wire logic tx_stop_o,
	input wire logic sleep_o,
	input wire logic [3:0] sw_flow_mode_o,
	input wire logic [7:0] modem_control_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	logic wr;
	assign wr = psel_i && penable_i && pready_o && pwrite_i;
	sequence s_ident_read;
		psel_i && penable_i && pready_o && !pwrite_i && paddr_i == `OFS_INTERRUPT_IDENT;
	endsequence
	AST_IRQ_MATCH: assert property (s_ident_read |-> irq_n_o == prdata_o[0])
		else $error("irq level disagrees with ident");
	AST_MIRROR: assert property (s_ident_read |-> prdata_o[7] == prdata_o[6])
		else $error("ident fifo bits differ");
	AST_CODE: assert property (s_ident_read |-> prdata_o[5:0] inside {6'h01, 6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20})
		else $error("ident code illegal");
	AST_RESET_STATE: assert property ($rose(arst_n_i) |-> irq_n_o && rts_n_o && !tx_stop_o && !sleep_o)
		else $error("state after reset wrong");
	AST_CTS_GO: assert property (!cts_n_i [*5] |=> !tx_stop_o)
		else $error("transmitter held with cts low");
	AST_SLEEP_SRC: assert property ($rose(sleep_o) |-> $past(wr && paddr_i == `OFS_INTERRUPT_ENABLE && pwdata_i[4]))
		else $error("sleep set without write");
	AST_MODE_SRC: assert property ($changed(sw_flow_mode_o) |-> $past(wr && paddr_i == `OFS_ENHANCED_FEATURE))
		else $error("flow mode changed without write");
	AST_MODEM_SRC: assert property ($changed(modem_control_o) |-> $past(wr && paddr_i == `OFS_MODEM_CONTROL))
		else $error("modem control changed without write");
endmodule

// ===== bench/test_uart_interrupt_flow_control.sv
`include "uart_ifc_regs.svh"

module test_uart_interrupt_flow_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [7:0] paddr_i, rx_char_i, fifo_control_o, modem_control_o;
	logic [31:0] pwdata_i, prdata_o, seed, mode;
	logic line_err_i, rx_timeout_i, rx_data_i, tx_below_i, rx_char_valid_i, xoff_rcvd_i;
	logic cts_n_i, dsr_n_i, ri_n_i, cd_n_i, irq_n_o, rts_n_o, dtr_n_o, tx_stop_o, sleep_o;
	logic [6:0] rx_level_i;
	logic [3:0] sw_flow_mode_o;
	int failures, n_checks, line, tmo, rxd, txp, mdm, xof, crs;
	int lv[5] = '{0, 16, 12, 8, 12};
	int ex[5] = '{0, 1, 1, 0, 0};
	uart_ifc_ctrl uart_ifc_ctrl_i (.ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .line_err_i, .rx_timeout_i, .rx_data_i, .tx_below_i, .rx_level_i,
		.rx_char_valid_i, .rx_char_i, .xoff_rcvd_i, .cts_n_i, .dsr_n_i, .ri_n_i, .cd_n_i, .irq_n_o, .rts_n_o,
		.dtr_n_o, .tx_stop_o, .sleep_o, .sw_flow_mode_o, .fifo_control_o, .modem_control_o);
	apb_host apb_host_i (.ref_clk_i, .pready_i(pready_o), .prdata_i(prdata_o), .psel_o(psel_i),
		.penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb_host_i.xfer(1'b1, a, d, r);
		// Let the write settle before outputs are compared
		@(posedge ref_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb_host_i.xfer(1'b0, a, 8'h00, r);
		chk(r, exp);
	endtask
	function automatic logic [5:0] pri();
		if (line) return 6'h06;
		if (tmo) return 6'h0C;
		if (rxd) return 6'h04;
		if (txp) return 6'h02;
		if (mdm) return 6'h00;
		if (xof) return 6'h10;
		if (crs) return 6'h20;
		return 6'h01;
	endfunction
	task automatic idchk();
		logic [5:0] c;
		repeat (4) @(posedge ref_clk_i);
		c = pri();
		chk({31'h0, irq_n_o}, {31'h0, c == 6'h01});
		rd(`OFS_INTERRUPT_IDENT, {24'h0, 2'b11, c});
		txp = txp && c != 6'h02;
		xof = xof && c != 6'h10;
		crs = crs && c != 6'h20;
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		failures++;
		complete_run();
	end
	initial
	begin
		seed = 32'hBB21;
		{line_err_i, rx_timeout_i, rx_data_i, tx_below_i, rx_char_valid_i, xoff_rcvd_i} = 6'h00;
		{cts_n_i, dsr_n_i, ri_n_i, cd_n_i} = 4'hF;
		rx_level_i = 7'h00;
		rx_char_i = 8'h00;
		arst_n_i = 1'b0;
		repeat (6) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		rd(`OFS_INTERRUPT_ENABLE, 32'h0);
		rd(`OFS_ENHANCED_FEATURE, 32'h0);
		wr(`OFS_INTERRUPT_ENABLE, 8'hFF);
		rd(`OFS_INTERRUPT_ENABLE, 32'h0F);
		wr(`OFS_FIFO_CONTROL, 8'h31);
		rd(`OFS_FIFO_CONTROL, 32'h01);
		mode = $random(seed);
		wr(`OFS_ENHANCED_FEATURE, {4'h1, mode[3:0]});
		chk({28'h0, sw_flow_mode_o}, {28'h0, mode[3:0]});
		wr(`OFS_INTERRUPT_ENABLE, 8'hFF);
		chk({31'h0, sleep_o}, 32'h1);
		wr(`OFS_INTERRUPT_ENABLE, 8'hEF);
		rd(`OFS_INTERRUPT_ENABLE, 32'hEF);
		// Levels and arming edge together, so priority is seen step by step
		{line_err_i, rx_timeout_i, rx_data_i, tx_below_i} <= 4'hF;
		line = 1;
		tmo = 1;
		rxd = 1;
		txp = 1;
		idchk();
		line_err_i <= 1'b0;
		line = 0;
		idchk();
		rx_timeout_i <= 1'b0;
		tmo = 0;
		idchk();
		rx_data_i <= 1'b0;
		rxd = 0;
		idchk();
		wr(`OFS_INTERRUPT_ENABLE, 8'hED);
		wr(`OFS_INTERRUPT_ENABLE, 8'hEF);
		idchk();
		{cts_n_i, ri_n_i} <= 2'b00;
		repeat (5) @(posedge ref_clk_i);
		{cts_n_i, ri_n_i} <= 2'b11;
		mdm = 1;
		crs = 1;
		idchk();
		rd(`OFS_MODEM_STATUS, 32'h05);
		mdm = 0;
		idchk();
		xoff_rcvd_i <= 1'b1;
		@(posedge ref_clk_i);
		xoff_rcvd_i <= 1'b0;
		xof = 1;
		idchk();
		wr(`OFS_SPECIAL_CHAR, 8'h5A);
		wr(`OFS_ENHANCED_FEATURE, {4'h3, mode[3:0]});
		for (int i = 0; i < 2; i++)
		begin
			rx_char_i <= i ? 8'h5A : 8'hA5;
			rx_char_valid_i <= 1'b1;
			@(posedge ref_clk_i);
			rx_char_valid_i <= 1'b0;
			xof = i;
			idchk();
		end
		wr(`OFS_ENHANCED_FEATURE, {4'h9, mode[3:0]});
		repeat (5) @(posedge ref_clk_i);
		chk({31'h0, tx_stop_o}, 32'h1);
		cts_n_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		chk({31'h0, tx_stop_o}, 32'h0);
		wr(`OFS_MODEM_CONTROL, 8'h40);
		chk({24'h0, modem_control_o}, 32'h40);
		chk({31'h0, dtr_n_o}, 32'h1);
		wr(`OFS_FLOW_THRESHOLD, 8'h24);
		wr(`OFS_ENHANCED_FEATURE, {4'h5, mode[3:0]});
		for (int i = 0; i < 5; i++)
		begin
			rx_level_i <= 7'(lv[i]);
			repeat (4) @(posedge ref_clk_i);
			chk({31'h0, rts_n_o}, 32'(ex[i]));
		end
		complete_run();
	end
endmodule

bind uart_ifc_ctrl uart_ifc_props uart_ifc_props_i (.ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .prdata_o, .pready_o, .cts_n_i, .irq_n_o, .rts_n_o, .tx_stop_o, .sleep_o,
	.sw_flow_mode_o, .modem_control_o);
